// File: logic/mode_code_pkg.sv
// package: control word layout, reset values and message event carriers for the mode code block
package mode_code_pkg;

    localparam int             WORD_WIDTH          = 16;
    localparam int             BIT_PINGPONG_ENABLE = 2;
    localparam int             BIT_STOP_REQUEST    = 3;
    localparam int             BIT_PINGPONG_ACK    = 8;
    localparam int             BIT_BROADCAST       = 9;
    localparam int             BIT_NEXT_BUFFER     = 10;
    localparam logic [4:0]     BROADCAST_ADDRESS   = 5'h1f;
    localparam logic [15:0]    WORD_RESET          = 16'h0000;
    localparam logic [15:0]    HOST_WRITE_MASK     = 16'h000c;

    // one message event from the protocol engine
    typedef struct packed {
        logic       start;
        logic       done;
        logic       error_free;
        logic       valid;
        logic       transmit;
        logic [4:0] rt_address;
    } message_type;

    // control word as seen by the buffer logic
    typedef struct packed {
        logic use_pingpong;
        logic pointer_b;
    } buffer_select_type;

    typedef enum logic [1:0] {
        IDLE_STATE = 2'b01,
        BUSY_STATE = 2'b10
    } phase_type;

endpackage

// File: logic/mode_code_pingpong_control.sv
// mode code control word: broadcast flag and ping-pong handshake
`timescale 1ns/1ns

// Behaviour
// - set broadcast flag on valid broadcast transmit
// - broadcast invalid option blocks the flag
// - resets clear flag; host cannot write it
// - enable bit selects ping-pong or indexed
// - ack negated when stopped, asserted when active
// - stopped: indexed on selected pointer, no toggle
// - pointer selects A or B, toggles after success
module mode_code_pingpong_control
    import mode_code_pkg::*;
(
    // clock and resets
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic                    master_reset,
    input  wire logic                    software_reset,
    // configuration
    input  wire logic                    broadcast_invalid,
    // host access to the control word
    input  wire logic                    host_write,
    input  wire logic [WORD_WIDTH-1:0]   host_write_data,
    output logic      [WORD_WIDTH-1:0]   host_read_data,
    // message events for this mode code
    input  message_type                  message,
    output buffer_select_type            buffer_select
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic      broadcast_received;
    logic      pingpong_enable;
    logic      stop_pingpong_request;
    logic      pingpong_ack;
    logic      next_buffer_select;
    phase_type phase;
    logic      message_stopped;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    wire logic any_reset      = reset | master_reset | software_reset;
    wire logic idle           = (phase == IDLE_STATE);
    wire logic is_broadcast   = (message.rt_address == BROADCAST_ADDRESS);
    wire logic broadcast_hit  = message.done & message.valid & message.transmit
                                & is_broadcast & ~broadcast_invalid;
    // stopped status is latched at message start so it holds across the message
    wire logic stopped_now    = pingpong_enable & ~pingpong_ack;
    wire logic toggle_pointer = message.done & message.error_free & ~phase[0]
                                & pingpong_enable & ~message_stopped;
    wire logic next_ack       = pingpong_enable & ~stop_pingpong_request;
    wire logic next_broadcast = broadcast_received | broadcast_hit;

    phase_type next_phase;
    always_comb
    begin
        case (phase)
            IDLE_STATE: next_phase = message.start ? BUSY_STATE : IDLE_STATE;
            BUSY_STATE: next_phase = message.done ? IDLE_STATE : BUSY_STATE;
            default:    next_phase = IDLE_STATE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (any_reset)
        begin
            broadcast_received    <= WORD_RESET[BIT_BROADCAST];
            pingpong_enable       <= WORD_RESET[BIT_PINGPONG_ENABLE];
            stop_pingpong_request <= WORD_RESET[BIT_STOP_REQUEST];
            pingpong_ack          <= WORD_RESET[BIT_PINGPONG_ACK];
            next_buffer_select    <= WORD_RESET[BIT_NEXT_BUFFER];
            phase                 <= IDLE_STATE;
            message_stopped       <= 1'b0;
        end
        else
        begin
            broadcast_received <= next_broadcast;
            phase              <= next_phase;
            if (host_write)
            begin
                // host may rewrite only enable and stop request
                pingpong_enable       <= host_write_data[BIT_PINGPONG_ENABLE];
                stop_pingpong_request <= host_write_data[BIT_STOP_REQUEST];
            end
            if (idle & ~message.start)
                pingpong_ack <= next_ack;
            if (idle & message.start)
                message_stopped <= stopped_now;
            if (toggle_pointer)
                next_buffer_select <= ~next_buffer_select;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (any_reset)
        begin
            host_read_data <= WORD_RESET;
            buffer_select  <= '0;
        end
        else
        begin
            host_read_data <= {5'h00, next_buffer_select, next_broadcast, pingpong_ack,
                               4'h0, stop_pingpong_request, pingpong_enable, 2'h0};
            buffer_select.use_pingpong <= pingpong_enable & ~stopped_now;
            buffer_select.pointer_b    <= next_buffer_select;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_BROADCAST_SET: assert property (@(posedge clk_sys) disable iff (any_reset)
        broadcast_hit |=> broadcast_received)
        else $error("broadcast flag not set");
    AST_BROADCAST_INVALID: assert property (@(posedge clk_sys) disable iff (any_reset)
        broadcast_invalid & ~broadcast_received |=> ~broadcast_received)
        else $error("broadcast flag set while invalid");
    AST_BROADCAST_HOLD: assert property (@(posedge clk_sys) disable iff (any_reset)
        broadcast_received |=> broadcast_received)
        else $error("broadcast flag lost without reset");
    AST_ACK_OFF: assert property (@(posedge clk_sys) disable iff (any_reset)
        idle & ~message.start & stop_pingpong_request |=> ~pingpong_ack)
        else $error("ack not negated on stop");
    AST_ACK_BUSY: assert property (@(posedge clk_sys) disable iff (any_reset)
        ~idle |=> $stable(pingpong_ack))
        else $error("ack changed during message");
    AST_NO_TOGGLE: assert property (@(posedge clk_sys) disable iff (any_reset)
        ~idle & message_stopped & message.done |=> $stable(next_buffer_select))
        else $error("pointer toggled while stopped");
    AST_TOGGLE: assert property (@(posedge clk_sys) disable iff (any_reset)
        toggle_pointer |=> next_buffer_select != $past(next_buffer_select))
        else $error("pointer did not toggle");
    AST_READBACK: assert property (@(posedge clk_sys) disable iff (any_reset)
        host_write ##1 ~host_write |=> host_read_data[BIT_PINGPONG_ENABLE]
            == $past(host_write_data[BIT_PINGPONG_ENABLE], 2))
        else $error("enable readback wrong");

    // ------------------------------------------------------------
    // checks: broadcast flag
    // ------------------------------------------------------------

    // any of the three resets must leave the flag clear
    AST_FLAG_RESET: assert property (@(posedge clk_sys)
        any_reset |=> ~broadcast_received)
        else $error("broadcast flag survived reset");

    // the flag only rises on an accepted broadcast transmit command
    AST_FLAG_QUIET: assert property (@(posedge clk_sys) disable iff (any_reset)
        ~broadcast_hit & ~broadcast_received |=> ~broadcast_received)
        else $error("broadcast flag set without command");

    // ------------------------------------------------------------
    // checks: handshake
    // ------------------------------------------------------------

    // a cleared stop request with ping-pong on must raise the ack
    AST_ACK_ON: assert property (@(posedge clk_sys) disable iff (any_reset)
        idle & ~message.start & pingpong_enable & ~stop_pingpong_request
        |=> pingpong_ack)
        else $error("ack not asserted on resume");

    // with indexed buffering selected the ack must stay low
    AST_ACK_ENABLE: assert property (@(posedge clk_sys) disable iff (any_reset)
        idle & ~message.start & ~pingpong_enable |=> ~pingpong_ack)
        else $error("ack asserted without enable");

    // host writes land in the stop request bit
    AST_STOP_WRITE: assert property (@(posedge clk_sys) disable iff (any_reset)
        host_write |=> stop_pingpong_request
            == $past(host_write_data[BIT_STOP_REQUEST]))
        else $error("stop request not stored");

    // the read word must carry the ack that was held a cycle ago
    AST_READ_ACK: assert property (@(posedge clk_sys) disable iff (any_reset)
        1'b1 |=> host_read_data[BIT_PINGPONG_ACK] == $past(pingpong_ack))
        else $error("ack readback wrong");

    // the phase must always hold exactly one state bit
    AST_PHASE_ONEHOT: assert property (@(posedge clk_sys) disable iff (any_reset)
        1'b1 |-> $onehot(phase))
        else $error("phase not one-hot");

    // ------------------------------------------------------------
    // checks: buffer selection
    // ------------------------------------------------------------

    // indexed mode never reports ping-pong buffering
    AST_INDEXED_MODE: assert property (@(posedge clk_sys) disable iff (any_reset)
        ~pingpong_enable |=> ~buffer_select.use_pingpong)
        else $error("ping-pong reported while disabled");

    // a suspended handshake forces single buffering
    AST_STOPPED_SINGLE: assert property (@(posedge clk_sys) disable iff (any_reset)
        stopped_now |=> ~buffer_select.use_pingpong)
        else $error("ping-pong reported while stopped");

    // the stopped status is captured at message start
    AST_STOP_LATCH: assert property (@(posedge clk_sys) disable iff (any_reset)
        idle & message.start |=> message_stopped == $past(stopped_now))
        else $error("stopped status not latched");

    // the pointer only moves on a counted completion
    AST_POINTER_HOLD: assert property (@(posedge clk_sys) disable iff (any_reset)
        ~toggle_pointer |=> $stable(next_buffer_select))
        else $error("pointer moved without completion");

    // the selected pointer reaches the buffer logic one cycle later
    AST_POINTER_OUT: assert property (@(posedge clk_sys) disable iff (any_reset)
        1'b1 |=> buffer_select.pointer_b == $past(next_buffer_select))
        else $error("pointer output wrong");

endmodule

// File: tb/host_model.sv
// host model: writes the mode code control word
`timescale 1ns/1ns
module host_model
    import mode_code_pkg::*;
(
    // control word write side
    input  wire logic              clk_sys,
    output logic                   host_write = 1'b0,
    output logic [WORD_WIDTH-1:0]  host_write_data = 16'h0000
);
    // stop set or cleared, enable written on every write, buffer left alone
    task automatic put(input logic [WORD_WIDTH-1:0] d);
        @(posedge clk_sys);
        #1 host_write = 1'b1;
        host_write_data = d;
        @(posedge clk_sys);
        #1 host_write = 1'b0;
        host_write_data = ~d;
    endtask
endmodule

// File: tb/tb_mode_code_pingpong_control.sv
// self-checking bench for the mode code control word
`timescale 1ns/1ns
module tb_mode_code_pingpong_control
    import mode_code_pkg::*;
;
    logic clk_sys = 1'b0, reset = 1'b1, master_reset = 1'b0, software_reset = 1'b0;
    logic broadcast_invalid = 1'b0, host_write, ptr = 1'b0;
    logic [WORD_WIDTH-1:0] host_write_data, host_read_data;
    message_type message = '0;
    buffer_select_type buffer_select;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    logic [31:0] seed = 32'hac09;
    always #4 clk_sys = ~clk_sys;
    host_model host (.clk_sys(clk_sys), .host_write(host_write), .host_write_data(host_write_data));
    mode_code_pingpong_control dut (.clk_sys(clk_sys), .reset(reset), .master_reset(master_reset),
        .software_reset(software_reset), .broadcast_invalid(broadcast_invalid),
        .host_write(host_write), .host_write_data(host_write_data),
        .host_read_data(host_read_data), .message(message), .buffer_select(buffer_select));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] word(input logic en, st, ack, bc, p);
        return {5'h00, p, bc, ack, 4'h0, st, en, 2'h0};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [15:0] d);
        host.put(d);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic msg(input logic ef, v, t, input logic [4:0] a);
        @(posedge clk_sys);
        #1 message = '{1'b1, 1'b0, 1'b0, v, t, a};
        @(posedge clk_sys);
        #1 message.start = 1'b0;
        @(posedge clk_sys);
        #1 message = '{1'b0, 1'b1, ef, v, t, a};
        @(posedge clk_sys);
        #1 message.done = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1 reset = 1'b0;
        msg(1'b1, 1'b1, 1'b0, 5'h02);
        check("indexed idle", host_read_data, WORD_RESET);
        wr(16'h0004 | (seed[15:0] & ~HOST_WRITE_MASK));
        check("enable", host_read_data, word(1, 0, 1, 0, 0));
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            msg(seed[0], 1'b1, seed[1], {seed[5:2], 1'b0});
            ptr ^= seed[0];
            check("pointer", host_read_data, word(1, 0, 1, 0, ptr));
        end
        wr(16'h000c);
        check("stopped", host_read_data, word(1, 1, 0, 0, ptr));
        msg(1'b1, 1'b1, 1'b0, 5'h03);
        check("no toggle", host_read_data, word(1, 1, 0, 0, ptr));
        check("single", {15'h0000, buffer_select.use_pingpong}, 16'h0000);
        wr(16'h0004);
        check("resumed", host_read_data, word(1, 0, 1, 0, ptr));
        broadcast_invalid = 1'b1;
        msg(1'b0, 1'b1, 1'b1, BROADCAST_ADDRESS);
        check("blocked", host_read_data, word(1, 0, 1, 0, ptr));
        broadcast_invalid = 1'b0;
        msg(1'b0, 1'b1, 1'b1, BROADCAST_ADDRESS);
        check("broadcast", host_read_data, word(1, 0, 1, 1, ptr));
        for (int j = 0; j < 2; j++)
        begin
            msg(1'b0, 1'b1, 1'b1, BROADCAST_ADDRESS);
            wr(16'h0004);
            {master_reset, software_reset} = j ? 2'b01 : 2'b10;
            @(posedge clk_sys);
            #1 {master_reset, software_reset} = 2'b00;
            @(posedge clk_sys);
            #1 check("reset clears", host_read_data, WORD_RESET);
        end
        tally_and_finish();
    end
endmodule
